// ### design/pep_pkg.sv
// package of constants for the paged memory host controller
package pep_pkg;
  localparam int CLK_MHZ = 250;
  // pin timing figures, in ns
  localparam int T_SETUP_NS = 50;
  localparam int T_PULSE_NS = 100;
  localparam int T_PULSE_HIGH_NS = 50;
  localparam int T_READ_NS = 150;
  localparam int T_HOLD_NS = 50;
  // derived cycle counts, least times rounded up
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_HIGH_CYC = (T_PULSE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  // byte load window, longest time, rounded down, in us
  localparam int BYTE_LOAD_WINDOW_US = 150;
  localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * CLK_MHZ;
  // programming and erase times, in us
  localparam int PROG_STD_US = 10000;
  localparam int PROG_FAST_US = 3000;
  localparam int ERASE_US = 10000;
  localparam int PROG_STD_CYC = PROG_STD_US * CLK_MHZ;
  localparam int PROG_FAST_CYC = PROG_FAST_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
  localparam int ERASE_EDGE_US = 5;
  localparam int ERASE_EDGE_CYC = ERASE_EDGE_US * CLK_MHZ;
  // field positions
  localparam int ADDR_W = 15;
  localparam int PAGE_LSB = 6;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int CNT_W = 32;
  typedef enum logic [1:0] {
    PEP_OP_READ,
    PEP_OP_WRITE,
    PEP_OP_ERASE
  } pep_op_t;
endpackage : pep_pkg

// ### design/pep_host.sv
// host controller driving the paged memory pins
`timescale 1ns/1ns
`default_nettype none
// Operation
// - erase: enable high voltage, strobe low 10ms
// - next strobe within 150us in page
// - same page lines on every strobe fall
// - enable stays high while strobe, select low
module pep_host
  import pep_pkg::*;
#(
  parameter int PROG_CYC = PROG_STD_CYC, // worst programming time, shorten in sim
  parameter int WINDOW_CYC = BYTE_LOAD_WINDOW_CYC, // byte load window
  parameter int ERASE_TIME_CYC = ERASE_CYC, // erase strobe length
  parameter int ERASE_EDGE_TIME_CYC = ERASE_EDGE_CYC // erase setup and hold
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic req_valid, // request present
  output logic req_ready, // request taken this cycle
  input wire logic [1:0] req_op, // pep_op_t code
  input wire logic [ADDR_W-1:0] req_addr, // byte address
  input wire logic [7:0] req_wdata, // write byte
  input wire logic req_last, // last byte of a page load
  input wire logic use_poll, // wait end by polling, else timer
  output logic rsp_valid, // one-cycle done pulse
  output logic [7:0] rsp_rdata, // read byte
  output logic busy, // controller neither idle nor waiting in an open page
  output logic chip_sel_n, // select pin, low active
  output logic out_en_n, // output enable pin, low active
  output logic erase_high_voltage_level, // raise enable to erase voltage
  output logic write_strobe_n, // write strobe pin, low active
  output logic [ADDR_W-1:0] mem_addr, // address pins
  input wire logic [7:0] data_i, // data pins sensed
  output logic [7:0] data_o, // data pins driven
  output logic data_oe // high while host drives data
);
  typedef enum logic [3:0] {
    PEP_IDLE, PEP_WSETUP, PEP_WPULSE, PEP_WHIGH, PEP_WWAIT,
    PEP_PROG, PEP_POLL, PEP_RSETUP, PEP_RREAD, PEP_ESETUP, PEP_EPULSE, PEP_EHOLD
  } pep_state_t;

  pep_state_t state_reg, state_next; // sequencer state
  logic [CNT_W-1:0] cnt_reg, cnt_next; // phase timer
  logic [CNT_W-1:0] win_reg, win_next; // time since last strobe fall
  logic [ADDR_W-1:0] addr_reg, addr_next; // address pins
  logic [ADDR_W-1:0] last_reg, last_next; // address of last byte written, for polling
  logic [7:0] wdat_reg, wdat_next; // data pins
  logic [7:0] exp_reg, exp_next; // last written byte
  logic [7:0] rdat_reg, rdat_next; // read result
  logic cs_reg, cs_next, oe_reg, oe_next, we_reg, we_next, hv_reg, hv_next, doe_reg, doe_next;
  logic done_reg, done_next; // response pulse
  logic lst_reg, lst_next; // page load closes after this byte
  logic poll_reg, poll_next; // polling mode latched

  // outputs straight from flops, busy decoded from the state, req_ready from the state, the request and the held page address
  assign chip_sel_n = cs_reg;
  assign out_en_n = oe_reg;
  assign write_strobe_n = we_reg;
  assign erase_high_voltage_level = hv_reg;
  assign mem_addr = addr_reg;
  assign data_o = wdat_reg;
  assign data_oe = doe_reg;
  assign rsp_valid = done_reg;
  assign rsp_rdata = rdat_reg;
  assign busy = (state_reg != PEP_IDLE) && (state_reg != PEP_WWAIT);
  // take requests only when idle or inside an open page load
  assign req_ready = req_valid && ((state_reg == PEP_IDLE) ||
    ((state_reg == PEP_WWAIT) && (pep_op_t'(req_op) == PEP_OP_WRITE) &&
     (req_addr[ADDR_W-1:PAGE_LSB] == addr_reg[ADDR_W-1:PAGE_LSB])));

  // next state and pin values
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 32'h1;
    win_next = win_reg + 32'h1;
    addr_next = addr_reg;
    last_next = last_reg;
    wdat_next = wdat_reg;
    exp_next = exp_reg;
    rdat_next = rdat_reg;
    cs_next = cs_reg;
    oe_next = oe_reg;
    we_next = we_reg;
    hv_next = hv_reg;
    doe_next = doe_reg;
    done_next = 1'b0;
    lst_next = lst_reg;
    poll_next = poll_reg;
    unique case (state_reg)
      PEP_IDLE: begin
        // parked in standby, device floats its pins
        cs_next = 1'b1;
        oe_next = 1'b1;
        we_next = 1'b1;
        doe_next = 1'b0;
        if (req_ready) begin
          addr_next = req_addr;
          wdat_next = req_wdata;
          lst_next = req_last;
          poll_next = use_poll;
          cnt_next = '0;
          cs_next = 1'b0;
          unique case (pep_op_t'(req_op))
            PEP_OP_WRITE: begin
              doe_next = 1'b1; // enable held high so device is off the bus
              state_next = PEP_WSETUP;
            end
            PEP_OP_ERASE: begin
              state_next = PEP_ESETUP;
            end
            default: begin
              oe_next = 1'b0;
              state_next = PEP_RSETUP;
            end
          endcase
        end
      end
      PEP_WSETUP: if (cnt_reg >= CNT_W'(SETUP_CYC - 1)) begin
        // strobe falls with select low and enable high
        we_next = 1'b0;
        cnt_next = '0;
        win_next = '0;
        state_next = PEP_WPULSE;
      end
      PEP_WPULSE: if (cnt_reg >= CNT_W'(PULSE_CYC - 1)) begin
        we_next = 1'b1; // data latched on this rise
        cnt_next = '0;
        last_next = addr_reg;
        exp_next = wdat_reg;
        state_next = PEP_WHIGH;
      end
      PEP_WHIGH: if (cnt_reg >= CNT_W'(PULSE_HIGH_CYC - 1)) begin
        doe_next = 1'b0;
        state_next = lst_reg ? PEP_PROG : PEP_WWAIT;
        cnt_next = '0;
      end
      PEP_WWAIT: begin
        // open page; strobe keeps enable high throughout
        if (req_ready) begin
          addr_next = req_addr; // low six bits pick the byte
          wdat_next = req_wdata;
          lst_next = req_last;
          doe_next = 1'b1;
          cnt_next = '0;
          state_next = PEP_WSETUP;
        end else if (win_reg >= CNT_W'(WINDOW_CYC / 2)) begin
          // margin against the window, device then programs
          lst_next = 1'b1;
          cnt_next = '0;
          state_next = PEP_PROG;
        end
      end
      PEP_PROG: begin
        // either wait the worst case or poll the status pins
        cs_next = 1'b1;
        if (poll_reg && cnt_reg >= CNT_W'(READ_CYC)) begin
          addr_next = last_reg;
          cs_next = 1'b0;
          oe_next = 1'b0;
          cnt_next = '0;
          state_next = PEP_POLL;
        end else if (cnt_reg >= CNT_W'(PROG_CYC)) begin
          done_next = 1'b1;
          state_next = PEP_IDLE;
        end
      end
      PEP_POLL: if (cnt_reg >= CNT_W'(READ_CYC)) begin
        cs_next = 1'b1;
        oe_next = 1'b1;
        cnt_next = '0;
        // true bit back means programming over
        if (data_i[POLL_BIT] == exp_reg[POLL_BIT]) begin
          done_next = 1'b1;
          state_next = PEP_IDLE;
        end else begin
          state_next = PEP_PROG;
        end
      end
      PEP_RSETUP: if (cnt_reg >= CNT_W'(READ_CYC - 1)) begin
        rdat_next = data_i;
        cnt_next = '0;
        cs_next = 1'b1;
        oe_next = 1'b1;
        state_next = PEP_RREAD;
      end
      PEP_RREAD: if (cnt_reg >= CNT_W'(HOLD_CYC - 1)) begin
        done_next = 1'b1;
        state_next = PEP_IDLE;
      end
      PEP_ESETUP: begin
        hv_next = 1'b1;
        if (cnt_reg >= CNT_W'(ERASE_EDGE_TIME_CYC)) begin
          we_next = 1'b0;
          cnt_next = '0;
          state_next = PEP_EPULSE;
        end
      end
      PEP_EPULSE: if (cnt_reg >= CNT_W'(ERASE_TIME_CYC)) begin
        we_next = 1'b1;
        cnt_next = '0;
        state_next = PEP_EHOLD;
      end
      PEP_EHOLD: if (cnt_reg >= CNT_W'(ERASE_EDGE_TIME_CYC)) begin
        hv_next = 1'b0;
        cs_next = 1'b1;
        done_next = 1'b1;
        state_next = PEP_IDLE;
      end
      default: state_next = PEP_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PEP_IDLE;
      cnt_reg <= '0;
      win_reg <= '0;
      addr_reg <= '0;
      last_reg <= '0;
      wdat_reg <= 8'h00;
      exp_reg <= 8'h00;
      rdat_reg <= 8'h00;
      cs_reg <= 1'b1;
      oe_reg <= 1'b1;
      we_reg <= 1'b1;
      hv_reg <= 1'b0;
      doe_reg <= 1'b0;
      done_reg <= 1'b0;
      lst_reg <= 1'b0;
      poll_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      win_reg <= win_next;
      addr_reg <= addr_next;
      last_reg <= last_next;
      wdat_reg <= wdat_next;
      exp_reg <= exp_next;
      rdat_reg <= rdat_next;
      cs_reg <= cs_next;
      oe_reg <= oe_next;
      we_reg <= we_next;
      hv_reg <= hv_next;
      doe_reg <= doe_next;
      done_reg <= done_next;
      lst_reg <= lst_next;
      poll_reg <= poll_next;
    end
  end
endmodule : pep_host
`default_nettype wire

// ### dv/pep_properties.sv
// pin assertions for the host controller
`timescale 1ns/1ns
`default_nettype none
module pep_properties
  import pep_pkg::*;
#(
  parameter int WINDOW_CYC = 100, // byte load window
  parameter int ERASE_TIME_CYC = 50 // erase strobe length
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, low active
  input wire logic rsp_valid, // done pulse
  input wire logic chip_sel_n, // select pin
  input wire logic out_en_n, // enable pin
  input wire logic erase_high_voltage_level, // erase voltage
  input wire logic write_strobe_n, // strobe pin
  input wire logic [ADDR_W-1:0] mem_addr, // address pins
  input wire logic [7:0] data_o, // data driven
  input wire logic data_oe // host drives data
);
  logic hv; // short alias
  logic we_reg; // strobe one cycle back
  logic [31:0] gap_reg, gap_next; // cycles since strobe fall
  logic [31:0] low_reg, low_next; // cycles strobe held low
  logic [ADDR_W-1:PAGE_LSB] page_reg, page_next; // page at last fall
  assign hv = erase_high_voltage_level;
  // helper counters
  always_comb begin
    gap_next = gap_reg + 32'h1;
    page_next = page_reg;
    low_next = write_strobe_n ? 32'h0 : low_reg + 32'h1;
    if (we_reg && !write_strobe_n && !hv) begin // a write fall, erase strobe left out
      gap_next = 32'h0;
      page_next = mem_addr[ADDR_W-1:PAGE_LSB];
    end
  end
  // start far away so the first strobe is free
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 32'h0FFF_FFFF;
      low_reg <= 32'h0;
      page_reg <= '0;
      we_reg <= 1'b1;
    end else begin
      gap_reg <= gap_next;
      low_reg <= low_next;
      page_reg <= page_next;
      we_reg <= write_strobe_n;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_fall;
    $fell(write_strobe_n) && !hv;
  endsequence
  sequence s_held;
    !write_strobe_n [*8];
  endsequence
  a_read_quiet: assert property (!chip_sel_n && !out_en_n && !hv
    |-> write_strobe_n && !data_oe)
    else $error("read overlaps strobe or host data");
  a_write_oe_high: assert property (!write_strobe_n && !chip_sel_n && !hv
    |-> out_en_n)
    else $error("enable low during write");
  a_strobe_ctx: assert property (s_fall |-> !chip_sel_n && data_oe)
    else $error("strobe without select or data");
  a_strobe_width: assert property (s_fall |-> s_held)
    else $error("strobe pulse too short");
  // the full least width is counted, the short form above only covers the start
  a_pulse_min: assert property ($rose(write_strobe_n) && !hv
    |-> low_reg >= PULSE_CYC)
    else $error("write strobe shorter than least pulse");
  a_addr_hold: assert property (!write_strobe_n && !$past(write_strobe_n) && !hv
    |-> $stable(mem_addr) && $stable(data_o))
    else $error("address or data moved in strobe");
  a_page_same: assert property (s_fall and (gap_reg < WINDOW_CYC)
    |-> mem_addr[ADDR_W-1:PAGE_LSB] == page_reg)
    else $error("page changed within load");
  a_erase_len: assert property ($rose(write_strobe_n) && hv
    |-> low_reg >= ERASE_TIME_CYC)
    else $error("erase strobe too short");
  a_erase_float: assert property (hv |-> !data_oe)
    else $error("host drives data in erase");
  a_erase_setup: assert property ($rose(hv) |-> write_strobe_n)
    else $error("voltage raised under strobe");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("done pulse longer than one cycle");
endmodule : pep_properties
`default_nettype wire

// ### dv/pep_mem_model.sv
// behavioural model of the paged memory device
`timescale 1ns/1ns
`default_nettype none
module pep_mem_model
  import pep_pkg::*;
#(
  parameter int PROG_NS = 600, // programming time
  parameter int ERASE_NS = 200 // least erase strobe
) (
  input wire logic mclk, // time base only
  input wire logic chip_sel_n, // select
  input wire logic out_en_n, // enable
  input wire logic hv, // erase voltage on enable
  input wire logic write_strobe_n, // strobe
  input wire logic [ADDR_W-1:0] addr, // address
  input wire logic [7:0] din, // data seen
  output logic [7:0] dq // data driven
);
  logic [7:0] mem [0:32767]; // array
  logic [7:0] last_d = 8'h0; // last byte written
  logic [7:0] last_q = 8'h0; // last byte driven
  logic tog = 1'b0; // toggle status
  logic busy = 1'b0; // programming
  logic [ADDR_W-1:0] lat_a; // captured address
  time busy_until = 0;
  time fall_t = 0;
  logic rd; // read decode
  assign rd = !chip_sel_n && !out_en_n && write_strobe_n && !hv;
  // address on the fall, inhibits block it
  always @(negedge write_strobe_n) begin
    fall_t = $time;
    if (!chip_sel_n && out_en_n && !hv) lat_a = addr;
  end
  // data on the rise; programming timer restarts per byte
  always @(posedge write_strobe_n) begin
    if (hv && !chip_sel_n && $time - fall_t >= ERASE_NS) begin
      for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
    end else if (!chip_sel_n && out_en_n && !hv) begin
      mem[lat_a] = din;
      last_d = din;
      busy_until = $time + PROG_NS;
    end
  end
  always @(negedge out_en_n) if (busy) tog = !tog;
  always @(posedge mclk) busy <= $time < busy_until;
  // released bus shows the inverse, never a stale value
  always @* begin
    if (rd && busy) dq = {~last_d[7], tog, mem[addr][5:0]};
    else if (rd) dq = mem[addr];
    else dq = ~last_q;
  end
  always @(posedge mclk) if (rd) last_q <= dq;
endmodule : pep_mem_model
`default_nettype wire

// ### dv/test_pep_host.sv
// self-checking bench for the host controller
`timescale 1ns/1ns
`default_nettype none
module test_pep_host;
  import pep_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_last = 1'b0, use_poll = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [ADDR_W-1:0] req_addr = '0, mem_addr;
  logic [7:0] req_wdata = 8'h0, rsp_rdata, data_o, dev_dq, data_i, d1, d2, d3;
  logic req_ready, rsp_valid, busy, chip_sel_n, out_en_n, hv, write_strobe_n, data_oe;
  logic [8:0] exp_q[$]; // compare flag and byte
  logic [8:0] e, pg;
  logic [5:0] o1, o2;
  logic [31:0] seed = 32'hC213;
  int errors = 0, num_checks = 0, cycles = 0;
  assign data_i = data_oe ? data_o : dev_dq; // wire level
  always #2 mclk = ~mclk;
  pep_host #(.PROG_CYC(200), .WINDOW_CYC(100), .ERASE_TIME_CYC(50), .ERASE_EDGE_TIME_CYC(5))
  u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_last(req_last),
    .use_poll(use_poll), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .erase_high_voltage_level(hv),
    .write_strobe_n(write_strobe_n), .mem_addr(mem_addr), .data_i(data_i), .data_o(data_o),
    .data_oe(data_oe));
  pep_mem_model u_mem (.mclk(mclk), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .hv(hv),
    .write_strobe_n(write_strobe_n), .addr(mem_addr), .din(data_i), .dq(dev_dq));
  task automatic fail(input string m);
    errors++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask : fail
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // one request, held until taken; note what it should answer
  task automatic op(input logic [1:0] k, input logic [14:0] a, input logic [7:0] d,
    input logic l, input logic p, input logic [8:0] x);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= k;
    req_addr <= a;
    req_wdata <= d;
    req_last <= l;
    use_poll <= p;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // a byte that leaves its page open gets no answer of its own
    if (k != 2'h1 || l) exp_q.push_back(x);
  endtask : op
  // watcher: oldest note against each answer, plus the hang limit
  // samples mid-cycle, where registered outputs have settled
  always @(negedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      fail("timeout");
      wrap_up();
    end else if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("answer without request");
      else begin
        e = exp_q.pop_front();
        if (e[8]) num_checks++;
        if (e[8] && rsp_rdata !== e[7:0]) fail("read data wrong");
      end
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    pg = 9'($random(seed));
    o1 = 6'($random(seed));
    o2 = o1 ^ 6'h2A;
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    d3 = ~d1;
    op(2'h2, 15'h0, 8'h0, 1'b0, 1'b0, 9'h0);
    op(2'h0, {pg, o2}, 8'h0, 1'b0, 1'b0, 9'h1FF);
    op(2'h1, {pg, o1}, d1, 1'b0, 1'b1, 9'h0);
    op(2'h1, {pg, o2}, d2, 1'b0, 1'b1, 9'h0);
    op(2'h1, {pg, o1}, d3, 1'b1, 1'b1, 9'h0);
    op(2'h0, {pg, o1}, 8'h0, 1'b0, 1'b0, {1'b1, d3});
    op(2'h0, {pg, o2}, 8'h0, 1'b0, 1'b0, {1'b1, d2});
    // open page left to the window, then the timer
    op(2'h1, {~pg, o1}, d1, 1'b0, 1'b0, 9'h0);
    exp_q.push_back(9'h0); // window closes the page, one answer due
    do @(posedge mclk); while (busy !== 1'b0);
    req_valid <= 1'b1;
    req_op <= 2'h1;
    req_addr <= {pg, o2};
    @(posedge mclk);
    num_checks++;
    if (req_ready !== 1'b0) fail("other page taken in open page");
    op(2'h1, {pg, o2}, 8'h5A, 1'b1, 1'b0, 9'h0);
    op(2'h0, {~pg, o1}, 8'h0, 1'b0, 1'b0, {1'b1, d1});
    op(2'h0, {pg, o2}, 8'h0, 1'b0, 1'b0, 9'h15A);
    repeat (120) @(posedge mclk);
    if (exp_q.size() != 0) fail("answers missing");
    wrap_up();
  end
endmodule : test_pep_host
bind pep_host pep_properties #(.WINDOW_CYC(WINDOW_CYC), .ERASE_TIME_CYC(ERASE_TIME_CYC))
  u_props (.mclk(mclk), .rst_n(rst_n), .rsp_valid(rsp_valid), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .erase_high_voltage_level(erase_high_voltage_level),
    .write_strobe_n(write_strobe_n), .mem_addr(mem_addr), .data_o(data_o), .data_oe(data_oe));
`default_nettype wire
